// ===== tmr_waveform_ctrl.sv
// 8-bit timer with two compare outputs, waveform mode control and ahb-lite registers
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_waveform_ctrl (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        extCountPin,
  input  wire logic        portOutA,
  input  wire logic        portDirA,
  input  wire logic        portOutB,
  input  wire logic        portDirB,
  input  wire logic        ackMatchA,
  input  wire logic        ackMatchB,
  input  wire logic        ackOverflow,
  output logic             pinOutA,
  output logic             pinOeA,
  output logic             pinOutB,
  output logic             pinOeB,
  output logic             matchFlagA,
  output logic             matchFlagB,
  output logic             overflowFlag
);

  logic [1:0]               rstPipe_r;
  logic                     rstSyncN;
  logic                     apValid_r;
  logic                     apWrite_r;
  logic [`TMR_IDX_W-1:0]    apIdx_r;
  logic [`TMR_IDX_W-1:0]    addrIdx;
  logic                     wrEn;
  logic [7:0]               wrData;
  logic [31:0]              hrdata_r;
  logic [1:0]               outAAction_r;
  logic [1:0]               outBAction_r;
  logic [1:0]               waveModeSel_r;
  logic                     waveModeHiBit_r;
  logic [2:0]               tickSourceSel_r;
  logic [7:0]               countValue_r;
  logic                     countDown_r;
  logic [7:0]               cmpABuf_r;
  logic [7:0]               cmpBBuf_r;
  logic [7:0]               cmpAAct_r;
  logic [7:0]               cmpBAct_r;
  logic                     matchFlagA_r;
  logic                     matchFlagB_r;
  logic                     overflowFlag_r;
  logic                     matchBlock_r;
  logic                     forceA_r;
  logic                     forceB_r;
  logic                     pinOutA_r;
  logic                     pinOeA_r;
  logic                     pinOutB_r;
  logic                     pinOeB_r;
  logic                     timerTickEnable;
  logic [2:0]               waveMode;
  tmr_pkg::tmr_cls_t        cls;
  logic [7:0]               topVal;
  logic                     atTop;
  logic                     topTick;
  logic                     matchA;
  logic                     matchB;
  logic                     overflowEvt;
  logic                     immediateUpd;
  logic                     clrA;
  logic                     clrB;
  logic                     clrOvf;

  // mode decoding, shared by counting, overflow, update timing and the output units
  function automatic tmr_pkg::tmr_cls_t modeClass(input logic [2:0] m);
    case (m)
      `TMR_WM_NORMAL:                    modeClass = tmr_pkg::CLS_NORMAL;
      `TMR_WM_CTC:                       modeClass = tmr_pkg::CLS_CTC;
      `TMR_WM_PC_FF, `TMR_WM_PC_CMPA:    modeClass = tmr_pkg::CLS_PHASE;
      `TMR_WM_FAST_FF, `TMR_WM_FAST_CMPA: modeClass = tmr_pkg::CLS_FAST;
      default:                           modeClass = tmr_pkg::CLS_RSVD;
    endcase
  endfunction : modeClass

  function automatic logic regHit(input logic [`TMR_IDX_W-1:0] idx,
                                  input logic [`TMR_IDX_W-1:0] want);
    regHit = (idx == want);
  endfunction : regHit

  // reset release through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe_r[1];

  // ahb-lite slave: zero wait states, always okay
  assign addrIdx = haddr[`TMR_IDX_W+1:2];
  assign wrEn    = apValid_r && apWrite_r;
  assign wrData  = hwdata[7:0];

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      apValid_r <= 1'b0;
      apWrite_r <= 1'b0;
      apIdx_r   <= '0;
    end else if (hready) begin
      apValid_r <= hsel && htrans[1];
      apWrite_r <= hwrite;
      apIdx_r   <= addrIdx;
    end else begin
      apValid_r <= 1'b0;
    end
  end

  // read data is sampled in the address phase so hrdata leaves a flop
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      hrdata_r <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata_r <= 32'h0000_0000;
      if (regHit(addrIdx, `TMR_IDX_CTRL_A)) begin
        hrdata_r[7:0] <= {outAAction_r, outBAction_r, 2'b00, waveModeSel_r};
      end else if (regHit(addrIdx, `TMR_IDX_CTRL_B)) begin
        hrdata_r[7:0] <= {4'h0, waveModeHiBit_r, tickSourceSel_r};
      end else if (regHit(addrIdx, `TMR_IDX_COUNT)) begin
        hrdata_r[7:0] <= countValue_r;
      end else if (regHit(addrIdx, `TMR_IDX_CMP_A)) begin
        hrdata_r[7:0] <= cmpABuf_r;
      end else if (regHit(addrIdx, `TMR_IDX_CMP_B)) begin
        hrdata_r[7:0] <= cmpBBuf_r;
      end else if (regHit(addrIdx, `TMR_IDX_FLAGS)) begin
        hrdata_r[7:0] <= {5'h00, matchFlagB_r, matchFlagA_r, overflowFlag_r};
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  assign hrdata = hrdata_r;

  // control registers
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      outAAction_r    <= 2'b00;
      outBAction_r    <= 2'b00;
      waveModeSel_r   <= 2'b00;
      waveModeHiBit_r <= 1'b0;
      tickSourceSel_r <= `TMR_SRC_STOP;
      cmpABuf_r       <= `TMR_RST_BYTE;
      cmpBBuf_r       <= `TMR_RST_BYTE;
    end else if (wrEn) begin
      if (regHit(apIdx_r, `TMR_IDX_CTRL_A)) begin
        outAAction_r  <= wrData[`TMR_A_ACT_A_HI:`TMR_A_ACT_A_LO];
        outBAction_r  <= wrData[`TMR_A_ACT_B_HI:`TMR_A_ACT_B_LO];
        waveModeSel_r <= wrData[`TMR_A_WAVE_HI:`TMR_A_WAVE_LO];
      end
      if (regHit(apIdx_r, `TMR_IDX_CTRL_B)) begin
        waveModeHiBit_r <= wrData[`TMR_B_WAVE_HI_BIT];
        tickSourceSel_r <= wrData[`TMR_B_SRC_HI:`TMR_B_SRC_LO];
      end
      if (regHit(apIdx_r, `TMR_IDX_CMP_A)) begin
        cmpABuf_r <= wrData;
      end
      if (regHit(apIdx_r, `TMR_IDX_CMP_B)) begin
        cmpBBuf_r <= wrData;
      end
    end
  end

  // force strobes act only in non-pwm modes; they never raise a flag
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      forceA_r <= 1'b0;
      forceB_r <= 1'b0;
    end else begin
      forceA_r <= wrEn && regHit(apIdx_r, `TMR_IDX_CTRL_B) && wrData[`TMR_B_FORCE_A];
      forceB_r <= wrEn && regHit(apIdx_r, `TMR_IDX_CTRL_B) && wrData[`TMR_B_FORCE_B];
    end
  end

  tmr_prescaler u_prescaler (
    .mclk        (mclk),
    .rstn        (rstSyncN),
    .tickSel     (tickSourceSel_r),
    .extCountPin (extCountPin),
    .tick        (timerTickEnable)
  );

  assign waveMode     = {waveModeHiBit_r, waveModeSel_r};
  assign cls          = modeClass(waveMode);
  assign topVal       = (waveMode == `TMR_WM_CTC || waveMode == `TMR_WM_PC_CMPA ||
                         waveMode == `TMR_WM_FAST_CMPA) ? cmpAAct_r : `TMR_MAX;
  assign atTop        = (countValue_r == topVal);
  assign topTick      = timerTickEnable && atTop && !countDown_r;
  assign immediateUpd = (cls != tmr_pkg::CLS_FAST) && (cls != tmr_pkg::CLS_PHASE);
  // a blocked tick still counts but sees no compare match
  assign matchA = timerTickEnable && !matchBlock_r && (countValue_r == cmpAAct_r);
  assign matchB = timerTickEnable && !matchBlock_r && (countValue_r == cmpBAct_r);

  always_comb begin
    case (cls)
      tmr_pkg::CLS_FAST:  overflowEvt = topTick;
      tmr_pkg::CLS_PHASE: overflowEvt = timerTickEnable && countDown_r &&
                                        (countValue_r == `TMR_BOTTOM);
      default:            overflowEvt = timerTickEnable &&
                                        (countValue_r == `TMR_MAX);
    endcase
  end

  // compare double buffer
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cmpAAct_r <= `TMR_RST_BYTE;
      cmpBAct_r <= `TMR_RST_BYTE;
    end else if (immediateUpd || topTick) begin
      cmpAAct_r <= cmpABuf_r;
      cmpBAct_r <= cmpBBuf_r;
    end
  end

  // counting sequence; a software write wins over the tick
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      countValue_r <= `TMR_BOTTOM;
      countDown_r  <= 1'b0;
    end else if (wrEn && regHit(apIdx_r, `TMR_IDX_COUNT)) begin
      countValue_r <= wrData;
    end else if (timerTickEnable) begin
      case (cls)
        tmr_pkg::CLS_CTC, tmr_pkg::CLS_FAST: begin
          countValue_r <= atTop ? `TMR_BOTTOM : countValue_r + 8'h01;
          countDown_r  <= 1'b0;
        end
        tmr_pkg::CLS_PHASE: begin
          if (!countDown_r && atTop) begin
            countDown_r  <= 1'b1;
            countValue_r <= countValue_r - 8'h01;
          end else if (countDown_r && countValue_r == `TMR_BOTTOM) begin
            countDown_r  <= 1'b0;
            countValue_r <= countValue_r + 8'h01;
          end else begin
            countValue_r <= countDown_r ? countValue_r - 8'h01 : countValue_r + 8'h01;
          end
        end
        default: begin
          countValue_r <= countValue_r + 8'h01;
          countDown_r  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      matchBlock_r <= 1'b0;
    end else if (wrEn && regHit(apIdx_r, `TMR_IDX_COUNT)) begin
      matchBlock_r <= 1'b1;
    end else if (timerTickEnable) begin
      matchBlock_r <= 1'b0;
    end
  end

  // flags: a set in the clearing cycle wins
  assign clrA   = ackMatchA   || (wrEn && regHit(apIdx_r, `TMR_IDX_FLAGS) && wrData[`TMR_F_MATCH_A]);
  assign clrB   = ackMatchB   || (wrEn && regHit(apIdx_r, `TMR_IDX_FLAGS) && wrData[`TMR_F_MATCH_B]);
  assign clrOvf = ackOverflow || (wrEn && regHit(apIdx_r, `TMR_IDX_FLAGS) && wrData[`TMR_F_OVF]);

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      matchFlagA_r   <= 1'b0;
      matchFlagB_r   <= 1'b0;
      overflowFlag_r <= 1'b0;
    end else begin
      matchFlagA_r   <= (matchFlagA_r & ~clrA) | matchA;
      matchFlagB_r   <= (matchFlagB_r & ~clrB) | matchB;
      overflowFlag_r <= (overflowFlag_r & ~clrOvf) | overflowEvt;
    end
  end
  assign matchFlagA   = matchFlagA_r;
  assign matchFlagB   = matchFlagB_r;
  assign overflowFlag = overflowFlag_r;

  tmr_cmp_if ifA ();
  tmr_cmp_if ifB ();

  assign ifA.cls       = cls;
  assign ifA.action    = outAAction_r;
  assign ifA.waveHi    = waveModeHiBit_r;
  assign ifA.match     = matchA;
  assign ifA.force_    = forceA_r;
  assign ifA.topTick   = topTick;
  assign ifA.countDown = countDown_r;
  assign ifA.eqTop     = outAAction_r[1] && (cmpAAct_r == topVal);
  assign ifB.cls       = cls;
  assign ifB.action    = outBAction_r;
  assign ifB.waveHi    = waveModeHiBit_r;
  assign ifB.match     = matchB;
  assign ifB.force_    = forceB_r;
  assign ifB.topTick   = topTick;
  assign ifB.countDown = countDown_r;
  assign ifB.eqTop     = outBAction_r[1] && (cmpBAct_r == topVal);

  tmr_out_unit #(.IS_CHAN_A(1'b1)) u_outA (
    .mclk (mclk),
    .rstn (rstSyncN),
    .cmp  (ifA.unit)
  );

  tmr_out_unit #(.IS_CHAN_A(1'b0)) u_outB (
    .mclk (mclk),
    .rstn (rstSyncN),
    .cmp  (ifB.unit)
  );

  // pin mux: the driver stays under the port direction bit in both cases
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pinOutA_r <= 1'b0;
      pinOeA_r  <= 1'b0;
      pinOutB_r <= 1'b0;
      pinOeB_r  <= 1'b0;
    end else begin
      pinOutA_r <= ifA.connected ? ifA.ocVal : portOutA;
      pinOeA_r  <= portDirA;
      pinOutB_r <= ifB.connected ? ifB.ocVal : portOutB;
      pinOeB_r  <= portDirB;
    end
  end
  assign pinOutA = pinOutA_r;
  assign pinOeA  = pinOeA_r;
  assign pinOutB = pinOutB_r;
  assign pinOeB  = pinOeB_r;

endmodule : tmr_waveform_ctrl

// ===== tmr_map.svh
// register indices, field positions, reset values and counter constants
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// register indices; the byte address is four times the index
`define TMR_IDX_W          10
`define TMR_IDX_FLAGS      10'h015
`define TMR_IDX_CTRL_A     10'h024
`define TMR_IDX_CTRL_B     10'h025
`define TMR_IDX_COUNT      10'h026
`define TMR_IDX_CMP_A      10'h027
`define TMR_IDX_CMP_B      10'h028

// control register a fields
`define TMR_A_ACT_A_HI     7
`define TMR_A_ACT_A_LO     6
`define TMR_A_ACT_B_HI     5
`define TMR_A_ACT_B_LO     4
`define TMR_A_WAVE_HI      1
`define TMR_A_WAVE_LO      0

// control register b fields
`define TMR_B_FORCE_A      7
`define TMR_B_FORCE_B      6
`define TMR_B_WAVE_HI_BIT  3
`define TMR_B_SRC_HI       2
`define TMR_B_SRC_LO       0

// flag register fields
`define TMR_F_MATCH_B      2
`define TMR_F_MATCH_A      1
`define TMR_F_OVF          0

// reset values
`define TMR_RST_CTRL_A     8'h00
`define TMR_RST_CTRL_B     8'h00
`define TMR_RST_BYTE       8'h00

// counter limits
`define TMR_MAX            8'hff
`define TMR_BOTTOM         8'h00

// wave mode codes
`define TMR_WM_NORMAL      3'h0
`define TMR_WM_PC_FF       3'h1
`define TMR_WM_CTC         3'h2
`define TMR_WM_FAST_FF     3'h3
`define TMR_WM_RSVD4       3'h4
`define TMR_WM_PC_CMPA     3'h5
`define TMR_WM_RSVD6       3'h6
`define TMR_WM_FAST_CMPA   3'h7

// tick source codes
`define TMR_SRC_STOP       3'h0
`define TMR_SRC_DIV1       3'h1
`define TMR_SRC_DIV8       3'h2
`define TMR_SRC_DIV64      3'h3
`define TMR_SRC_DIV256     3'h4
`define TMR_SRC_DIV1024    3'h5
`define TMR_SRC_EXT_FALL   3'h6
`define TMR_SRC_EXT_RISE   3'h7

// prescaler width, enough for the largest divider
`define TMR_DIV_W          10

`endif

// ===== tmr_pkg.sv
// types shared by the timer waveform control modules
package tmr_pkg;

  typedef enum logic [2:0] {
    CLS_NORMAL = 3'b000,
    CLS_CTC    = 3'b001,
    CLS_FAST   = 3'b010,
    CLS_PHASE  = 3'b011,
    CLS_RSVD   = 3'b100
  } tmr_cls_t;

  typedef logic [1:0] tmr_action_t;

endpackage : tmr_pkg

// ===== tmr_cmp_if.sv
// carrier between the counter core and one compare output unit
`timescale 1ns/1ps
interface tmr_cmp_if;
  tmr_pkg::tmr_cls_t    cls;
  tmr_pkg::tmr_action_t action;
  logic                 waveHi;
  logic                 match;
  logic                 force_;
  logic                 topTick;
  logic                 countDown;
  logic                 eqTop;
  logic                 ocVal;
  logic                 connected;

  modport core (
    output cls, action, waveHi, match, force_, topTick, countDown, eqTop,
    input  ocVal, connected
  );
  modport unit (
    input  cls, action, waveHi, match, force_, topTick, countDown, eqTop,
    output ocVal, connected
  );
endinterface : tmr_cmp_if

// ===== tmr_prescaler.sv
// tick source selection: prescaled io clock or edges of the external count pin
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_prescaler (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [2:0]  tickSel,
  input  wire logic        extCountPin,
  output logic             tick
);

  logic [`TMR_DIV_W-1:0] div_r;
  logic                  extPrev_r;

  // free running so a source change never waits for a restart
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      extPrev_r <= 1'b0;
    end else begin
      extPrev_r <= extCountPin;
    end
  end

  always_comb begin
    case (tickSel)
      `TMR_SRC_STOP:     tick = 1'b0;
      `TMR_SRC_DIV1:     tick = 1'b1;
      `TMR_SRC_DIV8:     tick = &div_r[2:0];
      `TMR_SRC_DIV64:    tick = &div_r[5:0];
      `TMR_SRC_DIV256:   tick = &div_r[7:0];
      `TMR_SRC_DIV1024:  tick = &div_r[9:0];
      `TMR_SRC_EXT_FALL: tick = extPrev_r & ~extCountPin;
      `TMR_SRC_EXT_RISE: tick = ~extPrev_r & extCountPin;
      default:           tick = 1'b0;
    endcase
  end

endmodule : tmr_prescaler

// ===== tmr_out_unit.sv
// one compare output: waveform state and connection for a channel
`timescale 1ns/1ps
module tmr_out_unit #(
  parameter bit IS_CHAN_A = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  tmr_cmp_if.unit          cmp
);

  logic oc_r;
  logic oc_nxt;
  logic conn;

  always_comb begin
    oc_nxt = oc_r;
    conn   = 1'b0;
    case (cmp.cls)
      tmr_pkg::CLS_NORMAL, tmr_pkg::CLS_CTC: begin
        conn = |cmp.action;
        if (cmp.match || cmp.force_) begin
          case (cmp.action)
            2'b01:   oc_nxt = ~oc_r;
            2'b10:   oc_nxt = 1'b0;
            2'b11:   oc_nxt = 1'b1;
            default: oc_nxt = oc_r;
          endcase
        end
      end
      tmr_pkg::CLS_FAST, tmr_pkg::CLS_PHASE: begin
        if (cmp.action == 2'b01) begin
          // toggle exists only on channel a with the high mode bit; b stays off
          conn = IS_CHAN_A && cmp.waveHi;
          if (conn && cmp.match) begin
            oc_nxt = ~oc_r;
          end
        end else if (cmp.action[1]) begin
          conn = 1'b1;
          if (cmp.match && !cmp.eqTop) begin
            if (cmp.cls == tmr_pkg::CLS_PHASE && cmp.countDown) begin
              oc_nxt = ~cmp.action[0];
            end else begin
              oc_nxt = cmp.action[0];
            end
          end
          // fast mode always acts at top; phase correct only when compare equals top
          if (cmp.topTick && (cmp.cls == tmr_pkg::CLS_FAST || cmp.eqTop)) begin
            oc_nxt = ~cmp.action[0];
          end
        end
      end
      default: begin
        conn = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oc_r <= 1'b0;
    end else begin
      oc_r <= oc_nxt;
    end
  end

  assign cmp.ocVal     = oc_r;
  assign cmp.connected = conn;

endmodule : tmr_out_unit

// ===== tmr_pin_load.sv
// pad model: the loads on both compare pins
`timescale 1ns/1ps
module tmr_pin_load (
  input  wire logic pinOutA,
  input  wire logic pinOeA,
  input  wire logic pinOutB,
  input  wire logic pinOeB,
  output logic      padA,
  output logic      padB
);
  // a released pad reads the pull-up, never a stale drive
  assign padA = pinOeA ? pinOutA : 1'b1;
  assign padB = pinOeB ? pinOutB : 1'b1;
endmodule : tmr_pin_load

// ===== tmr_waveform_ctrl_chk.sv
// port-level assertions for the timer waveform control
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_waveform_ctrl_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        portOutA,
  input wire logic        portDirA,
  input wire logic        portOutB,
  input wire logic        portDirB,
  input wire logic        ackMatchA,
  input wire logic        ackOverflow,
  input wire logic        pinOutA,
  input wire logic        pinOeA,
  input wire logic        pinOutB,
  input wire logic        pinOeB,
  input wire logic        matchFlagA,
  input wire logic        overflowFlag
);
  logic [9:0] idx_r;
  logic [7:0] ctlA_r;
  logic [3:0] up_r, offA_r, offB_r;
  logic       wr_r, hiBit_r, rdA, rsv, offA, offB;
  // mode shadows; pins lag them, so pin checks wait four quiet cycles
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {idx_r, wr_r, ctlA_r, hiBit_r, up_r, offA_r, offB_r} <= '0;
    end else begin
      idx_r   <= haddr[11:2];
      wr_r    <= hsel & htrans[1] & hwrite;
      ctlA_r  <= (wr_r && idx_r == `TMR_IDX_CTRL_A) ? hwdata[7:0] : ctlA_r;
      hiBit_r <= (wr_r && idx_r == `TMR_IDX_CTRL_B) ? hwdata[3] : hiBit_r;
      up_r    <= {up_r[2:0], 1'b1};
      offA_r  <= {offA_r[2:0], offA};
      offB_r  <= {offB_r[2:0], offB};
    end
  end
  assign rdA  = hsel & htrans[1] & !hwrite & haddr[11:2] == `TMR_IDX_CTRL_A;
  assign rsv  = hiBit_r & !ctlA_r[0];
  assign offA = ctlA_r[7:6] == 2'h0 || rsv || (ctlA_r[0] && ctlA_r[7:6] == 2'h1 && !hiBit_r);
  assign offB = ctlA_r[5:4] == 2'h0 || rsv || (ctlA_r[0] && ctlA_r[5:4] == 2'h1);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  oe_follow_a: assert property (&up_r |-> pinOeA == $past(portDirA))
    else $error("oe a lag");
  oe_b_follow_a: assert property (&up_r |-> pinOeB == $past(portDirB))
    else $error("oe b lag");
  port_a_pass_a: assert property (offA && &offA_r |-> pinOutA == $past(portOutA))
    else $error("pin a not port");
  port_b_pass_a: assert property (offB && &offB_r |-> pinOutB == $past(portOutB))
    else $error("pin b not port");
  flag_a_clear_a: assert property ($fell(matchFlagA) |-> $past(ackMatchA) || $past(hwrite, 2))
    else $error("flag a lost");
  ovf_clear_a: assert property ($fell(overflowFlag) |-> $past(ackOverflow) || $past(hwrite, 2))
    else $error("ovf lost");
  rsvd_zero_a: assert property (rdA |=> hrdata[3:2] == 2'h0)
    else $error("reserved bits set");
  ctl_back_a: assert property (rdA |=> hrdata[7:0] == {ctlA_r[7:4], 2'h0, ctlA_r[1:0]})
    else $error("ctrl a readback");
endmodule : tmr_waveform_ctrl_chk
bind tmr_waveform_ctrl tmr_waveform_ctrl_chk u_chk (.*);

// ===== tmr_waveform_ctrl_test.sv
// self-checking bench: registers, compare outputs and flags of the timer
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_waveform_ctrl_test;
  logic        mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ackA = 1'b0, ackOvf = 1'b0;
  logic        outA = 1'b0, dirA = 1'b0, outB = 1'b0, dirB = 1'b0, ext = 1'b0, ackB = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic        rdy, resp, pinA, oeA, pinB, oeB, padA, padB;
  wire  [2:0]  flg;
  int          num_errors = 0, samples_checked = 0, cyc = 0;
  tmr_waveform_ctrl u_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
    .hrdata(hrdata), .hreadyout(rdy), .hresp(resp), .extCountPin(ext), .portOutA(outA),
    .portDirA(dirA), .portOutB(outB), .portDirB(dirB), .ackMatchA(ackA), .ackMatchB(ackB),
    .ackOverflow(ackOvf), .pinOutA(pinA), .pinOeA(oeA), .pinOutB(pinB), .pinOeB(oeB),
    .matchFlagA(flg[0]), .matchFlagB(flg[1]), .overflowFlag(flg[2]));
  tmr_pin_load u_load (.pinOutA(pinA), .pinOeA(oeA), .pinOutB(pinB), .pinOeB(oeB),
    .padA(padA), .padB(padB));
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // entered right after an edge; read data is taken before that edge's updates land
  task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (rdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge mclk); while (rdy !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic flag_wait(input int b, input int lim);
    for (int k = 0; k < lim && flg[b] !== 1'b1; k++) @(posedge mclk);
    check(flg[b], 1);
  endtask : flag_wait
  // high cycles of pin a over n cycles, after a warm-up that lets buffered compares load
  task automatic duty(input int n, input int exp);
    int h;
    h = 0;
    repeat (300) @(posedge mclk);
    repeat (n) begin
      @(posedge mclk);
      h += pinA;
    end
    check(h, exp);
  endtask : duty
  // n rising edges on the external count pin, one tick each
  task automatic pulse(input int n);
    repeat (n) begin
      ext <= 1'b1;
      @(posedge mclk);
      ext <= 1'b0;
      @(posedge mclk);
    end
  endtask : pulse
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    bus(0, `TMR_IDX_CTRL_A, 0);
    check(q, 0);
    check({rdy, resp}, 2'b10);
    bus(1, `TMR_IDX_CTRL_A, 8'hff);
    bus(0, `TMR_IDX_CTRL_A, 0);
    check(q, 32'hf3);
    bus(1, 10'h3f0, 8'h5a);
    bus(0, 10'h3f0, 0);
    check(q, 0);
    dirA <= 1'b1;
    dirB <= 1'b1;
    bus(1, `TMR_IDX_CMP_A, 8'h05);
    bus(1, `TMR_IDX_CMP_B, 8'h03);
    bus(1, `TMR_IDX_CTRL_A, 8'h70);
    bus(1, `TMR_IDX_CTRL_B, 8'h01);
    flag_wait(0, 300);
    @(posedge mclk);
    check({padA, pinB, oeB, flg[1]}, 4'hf);
    ackA <= 1'b1;
    @(posedge mclk);
    ackA <= 1'b0;
    flag_wait(2, 300);
    check(flg[0], 0);
    bus(1, `TMR_IDX_FLAGS, 8'h01);
    @(posedge mclk);
    check(flg[2], 0);
    bus(1, `TMR_IDX_CMP_A, 8'h10);
    bus(1, `TMR_IDX_CTRL_A, 8'h42);
    bus(1, `TMR_IDX_FLAGS, 8'h02);
    flag_wait(0, 300);
    bus(1, `TMR_IDX_FLAGS, 8'h02);
    flag_wait(0, 30);
    bus(1, `TMR_IDX_CMP_A, 8'h80);
    bus(1, `TMR_IDX_CTRL_A, 8'h83);
    duty(256, 32'h81);
    bus(1, `TMR_IDX_CTRL_A, 8'h81);
    duty(510, 32'h100);
    bus(1, `TMR_IDX_CMP_A, 8'hff);
    bus(1, `TMR_IDX_CTRL_A, 8'h83);
    duty(256, 32'h100);
    // both compare states hold 1 here, so a low port level exposes a false connection
    outB <= 1'b0;
    bus(1, `TMR_IDX_CTRL_A, 8'h13);
    repeat (4) @(posedge mclk);
    check(pinB, 0);
    outA <= 1'b0;
    dirA <= 1'b0;
    bus(1, `TMR_IDX_CTRL_B, 8'h09);
    bus(1, `TMR_IDX_CTRL_A, 8'h40);
    repeat (4) @(posedge mclk);
    check({pinA, oeA, padA}, 3'b001);
    bus(1, `TMR_IDX_CTRL_B, 8'h07);
    bus(1, `TMR_IDX_COUNT, 8'h03);
    bus(1, `TMR_IDX_FLAGS, 8'h04);
    pulse(1);
    check(flg[1], 0);
    bus(0, `TMR_IDX_COUNT, 0);
    check(q, 4);
    bus(1, `TMR_IDX_COUNT, 8'h02);
    pulse(2);
    check(flg[1], 1);
    ackB <= 1'b1;
    @(posedge mclk);
    ackB <= 1'b0;
    @(posedge mclk);
    check(flg[1], 0);
    test_done();
  end
endmodule : tmr_waveform_ctrl_test
